// ===== sim/psc_power_supply_control_regs_tb_top.sv
/* psc_power_supply_control_regs_tb_top.sv: self-checking bench, axi-lite master.
   assumes psc_defines.vh on the include path and the monitor compiled first. */
`timescale 1ns/1ps
`include "psc_defines.vh"
module psc_power_supply_control_regs_tb_top;
    reg         clk = 1'b0;                     // 8 ns clock
    reg         rst = 1'b1;                     // sync reset
    reg  [17:0] awaddr = 18'h0, araddr = 18'h0; // byte addresses
    reg  [31:0] wdata = 32'h0;
    reg  [3:0]  wstrb = 4'h0;
    reg         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    wire        awready, wready, bvalid, arready, rvalid;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    wire [5:0]  outs;                           // control outputs
    wire [1:0]  sttl;                           // settle flags
    integer     errorCnt = 0, nCompared = 0, j, n;
    reg  [31:0] seed = 32'd57;                  // xorshift state
    reg  [7:0]  m [0:5];                        // expected register bytes
    reg  [15:0] ix [0:5];                       // register indices
    reg  [7:0]  d;
    psc_power_supply_control_regs #(.CORE_SETTLE_CYCLES(20), .BOOST_SETTLE_CYCLES(10)) dut (
        .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .logicRegHeavyLoad(outs[5]), .flashVoltageMode(outs[4]), .coreRegLevelSelect(outs[3]),
        .lcdRegHeavyLoad(outs[2]), .lcdRegSourceSelect(outs[1]), .boosterOn(outs[0]),
        .coreSettling(sttl[0]), .boostedSettling(sttl[1]));
    // clock generator
    initial forever #4 clk = ~clk;
    // xorshift source
    function [31:0] rnd;
        begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            rnd = seed;
        end
    endfunction
    // writable bits of each register
    function [7:0] msk(input integer k);
        case (k)
            0: msk = 8'h10;
            1: msk = 8'h03;
            2: msk = 8'h21;
            3: msk = 8'h01;
            4: msk = 8'hff;
            default: msk = 8'h00;
        endcase
    endfunction
    task give_verdict;
        begin
            $display("compared %0d mismatches %0d", nCompared, errorCnt);
            if (errorCnt == 0 && nCompared > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    task chk_d(input [31:0] g, input [31:0] e);
        begin
            nCompared++;
            if (g !== e) begin
                errorCnt++;
                $display("mismatch t=%0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task chk_r(input [1:0] g, input [1:0] e);
        chk_d({30'h0, g}, {30'h0, e});
    endtask
    // bounded wait guard
    task tmo(input integer k);
        if (k > 200) begin
            errorCnt++;
            give_verdict;
        end
    endtask
    // axi write, both halves offered together, sp idles one cycle first
    task wr(input [15:0] i, input [7:0] v, input s, input sp, input [1:0] er);
        integer k;
        reg a, w;
        begin
            a = 1;
            w = 1;
            if (sp) @(posedge clk);
            awaddr <= {i, 2'b00};
            wdata <= (rnd() << 8) | v;
            wstrb <= {3'h7, s};
            awvalid <= 1;
            wvalid <= 1;
            for (k = 0; a || w; k++) begin
                @(posedge clk);
                tmo(k);
                if (awvalid && awready) a = 0;
                if (wvalid && wready) w = 0;
                awvalid <= a;
                wvalid <= w;
            end
            repeat (rnd() % 3) @(posedge clk);
            bready <= 1;
            k = 0;
            do begin @(posedge clk); tmo(k); k++; end while (bvalid !== 1'b1);
            chk_r(bresp, er);
            bready <= 0;
        end
    endtask
    // axi read with expected byte and response
    task rd(input [15:0] i, input [7:0] ed, input [1:0] er);
        integer k;
        begin
            araddr <= {i, 2'b00};
            arvalid <= 1;
            k = 0;
            do begin @(posedge clk); tmo(k); k++; end while (arready !== 1'b1);
            arvalid <= 0;
            repeat (rnd() % 3) @(posedge clk);
            rready <= 1;
            k = 0;
            do begin @(posedge clk); tmo(k); k++; end while (rvalid !== 1'b1);
            chk_d(rdata, {24'h0, ed});
            chk_r(rresp, er);
            rready <= 0;
        end
    endtask
    // write through the model: level select gated by the key
    task wm(input integer k, input [7:0] v, input s, input sp);
        begin
            wr(ix[k], v, s, sp, `PSC_RESP_OKAY);
            if (s && (k != 3 || m[4] == `PSC_KEY_UNLOCK)) m[k] = v & msk(k);
        end
    endtask
    task chk_outs;
        chk_d({26'h0, outs}, {26'h0, m[2][5], m[2][0], m[3][0], m[0][4], m[1][1], m[1][0]});
    endtask
    // reset then check every reset value
    task reset_chk;
        begin
            rst <= 1;
            repeat (16) @(posedge clk);
            rst <= 0;
            for (n = 0; n < 6; n++) m[n] = 8'h00;
            for (n = 0; n < 6; n++) rd(ix[n], 8'h00, `PSC_RESP_OKAY);
            chk_outs;
            $display("test reset done");
        end
    endtask
    initial begin
        ix[0] = `PSC_IDX_LCD_REGULATOR_CONTROL;
        ix[1] = `PSC_IDX_LCD_POWER_BOOSTER_CONTROL;
        ix[2] = `PSC_IDX_LOGIC_REGULATOR_CONTROL;
        ix[3] = `PSC_IDX_REGULATOR_LEVEL_SELECT;
        ix[4] = `PSC_IDX_MISC_WRITE_KEY;
        ix[5] = `PSC_IDX_SETTLE_STATUS;
        reset_chk;
        // key opens, wrong key keeps level select, strobe off ignored
        wm(4, 8'h96, 1, 0);
        wm(3, 8'hff, 1, 1);
        wm(4, 8'h5a, 1, 0);
        wm(3, 8'h00, 1, 0);
        rd(ix[3], m[3], `PSC_RESP_OKAY);
        wm(2, 8'hff, 0, 1);
        rd(ix[2], m[2], `PSC_RESP_OKAY);
        wr(16'h5000, 8'hff, 1, 0, `PSC_RESP_SLVERR);
        rd(16'h5126, 8'h00, `PSC_RESP_SLVERR);
        $display("test corners done");
        // random traffic over all writable registers
        repeat (80) begin
            j = rnd() % 5;
            d = rnd();
            if (j == 4 && rnd() % 2) d = `PSC_KEY_UNLOCK;
            wm(j, d, rnd() % 4 != 0, rnd() % 2);
            rd(ix[j], m[j], `PSC_RESP_OKAY);
            chk_outs;
        end
        $display("test random done");
        // booster start flags settling, which clears later
        repeat (60) @(posedge clk);
        wm(1, 8'h00, 1, 0);
        wm(1, 8'h01, 1, 0);
        rd(ix[5], 8'h02, `PSC_RESP_OKAY);
        chk_d({30'h0, sttl}, 32'h2);
        repeat (30) @(posedge clk);
        rd(ix[5], 8'h00, `PSC_RESP_OKAY);
        // source to boosted after settle, then back to supply
        wm(1, 8'h03, 1, 0);
        wm(1, 8'h00, 1, 0);
        // flash sequence: select then mode cleared, mode set, settle, select
        wm(4, `PSC_KEY_UNLOCK, 1, 0);
        wm(3, 8'h00, 1, 0);
        wm(4, 8'h5a, 1, 0);
        wm(2, 8'h00, 1, 0);
        repeat (30) @(posedge clk);
        wm(2, 8'h01, 1, 0);
        rd(ix[5], 8'h01, `PSC_RESP_OKAY);
        chk_d({30'h0, sttl}, 32'h1);
        repeat (30) @(posedge clk);
        rd(ix[5], 8'h00, `PSC_RESP_OKAY);
        wm(4, `PSC_KEY_UNLOCK, 1, 0);
        wm(3, 8'h01, 1, 0);
        wm(4, 8'h5a, 1, 0);
        chk_outs;
        $display("test settle done");
        reset_chk;
        give_verdict;
    end
endmodule
bind psc_power_supply_control_regs psc_pscr_monitor mon (
    .clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .logicRegHeavyLoad(logicRegHeavyLoad), .flashVoltageMode(flashVoltageMode),
    .coreRegLevelSelect(coreRegLevelSelect), .lcdRegHeavyLoad(lcdRegHeavyLoad),
    .lcdRegSourceSelect(lcdRegSourceSelect), .boosterOn(boosterOn), .coreSettling(coreSettling),
    .boostedSettling(boostedSettling));

// ===== sim/psc_pscr_monitor.sv
/* psc_pscr_monitor.sv: port assertions for the power control register block.
   assumes a bind from the bench top, one clock clk, sync reset rst. */
`timescale 1ns/1ps
module psc_pscr_monitor (
    input wire        clk,
    input wire        rst,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        logicRegHeavyLoad,
    input wire        flashVoltageMode,
    input wire        coreRegLevelSelect,
    input wire        lcdRegHeavyLoad,
    input wire        lcdRegSourceSelect,
    input wire        boosterOn,
    input wire        coreSettling,
    input wire        boostedSettling
);
    // one clock domain for every check
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    wire [5:0] ctl = {logicRegHeavyLoad, flashVoltageMode, coreRegLevelSelect,
                      lcdRegHeavyLoad, lcdRegSourceSelect, boosterOn};
    // both write halves taken at one edge
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // response offered but not yet taken
    sequence s_b_wait;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    a_write_answer: assert property (s_wr_both |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    a_bresp_hold: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_busy_no_take: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during answer");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_ctl_on_write: assert property (!$stable(ctl) |-> $rose(s_axi_bvalid))
        else $error("control changed outside a write");
    a_core_settle: assert property (!$stable({flashVoltageMode, coreRegLevelSelect}) |-> ##[0:2] coreSettling)
        else $error("core settle flag missing");
    a_boost_settle: assert property ($rose(boosterOn) |-> ##[0:2] boostedSettling)
        else $error("booster settle flag missing");
endmodule

// ===== verilog/psc_defines.vh
/*
 * psc_defines.vh: register offsets, field positions, reset values, key value
 * and timing figures of the power supply control register block.
 * Assumes it is included by bare name; holds definitions only.
 */
`ifndef PSC_DEFINES_VH
`define PSC_DEFINES_VH

// printed offsets are not all multiples of four: indices, byte address = 4 * index
`define PSC_IDX_LCD_REGULATOR_CONTROL     16'h50a3
`define PSC_IDX_LCD_POWER_BOOSTER_CONTROL 16'h50a4
`define PSC_IDX_LOGIC_REGULATOR_CONTROL   16'h5120
`define PSC_IDX_REGULATOR_LEVEL_SELECT    16'h5122
`define PSC_IDX_MISC_WRITE_KEY            16'h5124
`define PSC_IDX_SETTLE_STATUS             16'h5125

// field positions
`define PSC_BIT_LOGIC_REG_HEAVY_LOAD      5
`define PSC_BIT_FLASH_VOLTAGE_MODE        0
`define PSC_BIT_CORE_REG_LEVEL_SELECT     0
`define PSC_BIT_LCD_REG_HEAVY_LOAD        4
`define PSC_BIT_LCD_REG_SOURCE_SELECT     1
`define PSC_BIT_BOOSTER_ON                0
`define PSC_BIT_CORE_SETTLING             0
`define PSC_BIT_BOOSTED_SETTLING          1

// reset values
`define PSC_RST_REG8                      8'h00
`define PSC_RST_KEY                       8'h00

// key that opens the regulator level select register
`define PSC_KEY_UNLOCK                    8'h96

// settle times in microseconds, clock in MHz
`define PSC_CORE_SETTLE_US                5000
`define PSC_BOOST_SETTLE_US               1000
`define PSC_CLK_MHZ                       125

// axi response codes
`define PSC_RESP_OKAY                     2'b00
`define PSC_RESP_SLVERR                   2'b10

`endif

// ===== verilog/psc_power_supply_control_regs.v
/*
 * psc_power_supply_control_regs.v: AXI4-Lite register block that controls the
 * core logic regulator, the LCD regulator and the LCD voltage booster.
 * Assumes a single clock, synchronous active-high reset, one AXI master.
 * Only byte lane 0 of write data is used; read data bits 31:8 are zero.
 * The settle flags are status only; software keeps its own timing rules.
 * Register index times four gives the byte address on the bus.
 */
// Behaviour
// - logic heavy-load bit 5, read/write, reset 0
// - mode bit 0 selects core voltage level
// - level select writable only with key 0x96
// - level select bit 0, read/write, reset 0
// - LCD heavy-load bit 4, read/write, reset 0
// - source select bit 1 picks boosted voltage
// - booster-on bit 0, reset 0
`timescale 1ns/1ps
`include "psc_defines.vh"

module psc_power_supply_control_regs #(
    // default settle counts assume a 125 MHz clock
    parameter integer CORE_SETTLE_CYCLES  = `PSC_CORE_SETTLE_US * `PSC_CLK_MHZ,
    parameter integer BOOST_SETTLE_CYCLES = `PSC_BOOST_SETTLE_US * `PSC_CLK_MHZ,
    parameter integer ADDR_WIDTH          = 18
) (
    input  wire                  clk,
    input  wire                  rst,
    // write address channel
    input  wire [ADDR_WIDTH-1:0] s_axi_awaddr,
    input  wire [2:0]            s_axi_awprot,
    input  wire                  s_axi_awvalid,
    output wire                  s_axi_awready,
    // write data channel
    input  wire [31:0]           s_axi_wdata,
    input  wire [3:0]            s_axi_wstrb,
    input  wire                  s_axi_wvalid,
    output wire                  s_axi_wready,
    // write response channel
    output reg  [1:0]            s_axi_bresp,
    output reg                   s_axi_bvalid,
    input  wire                  s_axi_bready,
    // read address channel
    input  wire [ADDR_WIDTH-1:0] s_axi_araddr,
    input  wire [2:0]            s_axi_arprot,
    input  wire                  s_axi_arvalid,
    output wire                  s_axi_arready,
    // read data channel
    output reg  [31:0]           s_axi_rdata,
    output reg  [1:0]            s_axi_rresp,
    output reg                   s_axi_rvalid,
    input  wire                  s_axi_rready,
    // regulator and booster controls
    output reg                   logicRegHeavyLoad,
    output reg                   flashVoltageMode,
    output reg                   coreRegLevelSelect,
    output reg                   lcdRegHeavyLoad,
    output reg                   lcdRegSourceSelect,
    output reg                   boosterOn,
    // settle status flags
    output wire                  coreSettling,
    output wire                  boostedSettling
);
    // register selects, one-hot
    localparam [5:0] SEL_NONE  = 6'h00;
    localparam [5:0] SEL_LCDRC = 6'h01;
    localparam [5:0] SEL_LCDPB = 6'h02;
    localparam [5:0] SEL_LOGRC = 6'h04;
    localparam [5:0] SEL_LVSEL = 6'h08;
    localparam [5:0] SEL_KEY   = 6'h10;
    localparam [5:0] SEL_STAT  = 6'h20;

    // byte address from register index
    function [ADDR_WIDTH-1:0] idxAddr;
        input [15:0] idx;
        begin
            // index bits above the bus width drop out
            idxAddr = {idx[ADDR_WIDTH-3:0], 2'b00};
        end
    endfunction

    // decode a byte address to a one-hot register select
    function [5:0] decode;
        input [ADDR_WIDTH-1:0] addr;
        begin
            if (addr == idxAddr(`PSC_IDX_LCD_REGULATOR_CONTROL)) begin
                decode = SEL_LCDRC;
            end else if (addr == idxAddr(`PSC_IDX_LCD_POWER_BOOSTER_CONTROL)) begin
                decode = SEL_LCDPB;
            end else if (addr == idxAddr(`PSC_IDX_LOGIC_REGULATOR_CONTROL)) begin
                decode = SEL_LOGRC;
            end else if (addr == idxAddr(`PSC_IDX_REGULATOR_LEVEL_SELECT)) begin
                decode = SEL_LVSEL;
            end else if (addr == idxAddr(`PSC_IDX_MISC_WRITE_KEY)) begin
                decode = SEL_KEY;
            end else if (addr == idxAddr(`PSC_IDX_SETTLE_STATUS)) begin
                decode = SEL_STAT;
            end else begin
                // unmapped offsets select nothing
                decode = SEL_NONE;
            end
        end
    endfunction

    // write channel holding registers
    reg                  awHeld_q;     // address captured
    reg [ADDR_WIDTH-1:0] awAddr_q;     // captured address
    reg                  wHeld_q;      // data captured
    reg [7:0]            wByte_q;      // captured low byte
    reg                  wLane_q;      // low byte lane strobe
    reg [7:0]            miscWriteKey_q; // protection key register

    // write strobes and key gate
    wire       doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;  // both halves present
    wire [5:0] wSel    = decode(awAddr_q);                      // write target
    wire       wEn     = doWrite & wLane_q;                     // byte lane enabled
    wire       keyOpen = (miscWriteKey_q == `PSC_KEY_UNLOCK);   // level select unlocked

    // accept address and data independently, one write at a time
    assign s_axi_awready = ~awHeld_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~wHeld_q & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    // capture write address and data
    always @(posedge clk) begin
        if (rst) begin
            // nothing held after reset
            awHeld_q <= 1'b0;
            awAddr_q <= {ADDR_WIDTH{1'b0}};
            wHeld_q  <= 1'b0;
            wByte_q  <= 8'h00;
            wLane_q  <= 1'b0;
        end else begin
            // address half taken
            if (s_axi_awvalid & s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end else if (doWrite) begin
                awHeld_q <= 1'b0;
            end
            // data half taken
            if (s_axi_wvalid & s_axi_wready) begin
                wHeld_q <= 1'b1;
                wByte_q <= s_axi_wdata[7:0];
                wLane_q <= s_axi_wstrb[0];
            end else if (doWrite) begin
                wHeld_q <= 1'b0;
            end
        end
    end

    // write response, slverr for unmapped
    always @(posedge clk) begin
        if (rst) begin
            // no response pending
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `PSC_RESP_OKAY;
        end else if (doWrite) begin
            // answer once both halves meet
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wSel == SEL_NONE) ? `PSC_RESP_SLVERR : `PSC_RESP_OKAY;
        end else if (s_axi_bready) begin
            // master took the response
            s_axi_bvalid <= 1'b0;
        end
    end

    // control registers, only documented bits hold state
    always @(posedge clk) begin
        if (rst) begin
            // every control bit and the key clear
            logicRegHeavyLoad  <= 1'b0;
            flashVoltageMode   <= 1'b0;
            coreRegLevelSelect <= 1'b0;
            lcdRegHeavyLoad    <= 1'b0;
            lcdRegSourceSelect <= 1'b0;
            boosterOn          <= 1'b0;
            miscWriteKey_q     <= `PSC_RST_KEY;
        end else if (wEn) begin
            // route by decoded target
            case (wSel)
                SEL_LOGRC: begin
                    logicRegHeavyLoad <= wByte_q[`PSC_BIT_LOGIC_REG_HEAVY_LOAD];
                    flashVoltageMode  <= wByte_q[`PSC_BIT_FLASH_VOLTAGE_MODE];
                end
                SEL_LVSEL: begin
                    if (keyOpen) begin
                        coreRegLevelSelect <= wByte_q[`PSC_BIT_CORE_REG_LEVEL_SELECT];
                    end
                end
                SEL_LCDRC: begin
                    lcdRegHeavyLoad <= wByte_q[`PSC_BIT_LCD_REG_HEAVY_LOAD];
                end
                SEL_LCDPB: begin
                    lcdRegSourceSelect <= wByte_q[`PSC_BIT_LCD_REG_SOURCE_SELECT];
                    boosterOn          <= wByte_q[`PSC_BIT_BOOSTER_ON];
                end
                SEL_KEY: begin
                    // key register keeps the whole byte
                    miscWriteKey_q <= wByte_q;
                end
                default: begin
                    // status and unmapped: writes dropped
                end
            endcase
        end
    end

    // settle timers restart when core level or mode bit changes, or booster turns on
    // mode bit or unlocked level bit changed
    wire coreChange  = wEn & (((wSel == SEL_LOGRC) &
                       (wByte_q[`PSC_BIT_FLASH_VOLTAGE_MODE] != flashVoltageMode)) |
                       ((wSel == SEL_LVSEL) & keyOpen &
                       (wByte_q[`PSC_BIT_CORE_REG_LEVEL_SELECT] != coreRegLevelSelect)));
    // booster start only on an off to on write
    wire boostStart  = wEn & (wSel == SEL_LCDPB) & ~boosterOn & wByte_q[`PSC_BIT_BOOSTER_ON];

    psc_settle_timer #(
        .CYCLES (CORE_SETTLE_CYCLES),
        .WIDTH  (20)
    ) uCoreTimer (
        .clk   (clk),
        .rst   (rst),
        .start (coreChange),
        .busy  (coreSettling)
    );

    psc_settle_timer #(
        .CYCLES (BOOST_SETTLE_CYCLES),
        .WIDTH  (20)
    ) uBoostTimer (
        .clk   (clk),
        .rst   (rst),
        .start (boostStart),
        .busy  (boostedSettling)
    );

    // read data mux
    reg [7:0] rByte;  // selected register byte
    always @* begin
        rByte = 8'h00;
        case (decode(s_axi_araddr))
            SEL_LOGRC: begin
                rByte[`PSC_BIT_LOGIC_REG_HEAVY_LOAD] = logicRegHeavyLoad;
                rByte[`PSC_BIT_FLASH_VOLTAGE_MODE]   = flashVoltageMode;
            end
            SEL_LVSEL: begin
                rByte[`PSC_BIT_CORE_REG_LEVEL_SELECT] = coreRegLevelSelect;
            end
            SEL_LCDRC: begin
                rByte[`PSC_BIT_LCD_REG_HEAVY_LOAD] = lcdRegHeavyLoad;
            end
            SEL_LCDPB: begin
                rByte[`PSC_BIT_LCD_REG_SOURCE_SELECT] = lcdRegSourceSelect;
                rByte[`PSC_BIT_BOOSTER_ON]            = boosterOn;
            end
            SEL_KEY: begin
                // key reads back whole
                rByte = miscWriteKey_q;
            end
            SEL_STAT: begin
                // settle flags, read only
                rByte[`PSC_BIT_CORE_SETTLING]  = coreSettling;
                rByte[`PSC_BIT_BOOSTED_SETTLING] = boostedSettling;
            end
            default: begin
                // unmapped reads zero
                rByte = 8'h00;
            end
        endcase
    end

    // read response, one cycle after address
    always @(posedge clk) begin
        if (rst) begin
            // no read data pending
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `PSC_RESP_OKAY;
        end else if (s_axi_arvalid & s_axi_arready) begin
            // capture byte and response
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rByte};
            s_axi_rresp  <= (decode(s_axi_araddr) == SEL_NONE) ? `PSC_RESP_SLVERR : `PSC_RESP_OKAY;
        end else if (s_axi_rready) begin
            // master took the data
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ===== verilog/psc_settle_timer.v
/*
 * psc_settle_timer.v: counts a settle interval after each start pulse.
 * Assumes start comes from logic on the same clock; restarts on every start.
 */
`timescale 1ns/1ps

module psc_settle_timer #(
    parameter integer CYCLES = 1000,
    parameter integer WIDTH  = 20
) (
    input  wire clk,
    input  wire rst,
    input  wire start,
    output reg  busy
);
    reg [WIDTH-1:0] count_q;  // cycles still to run

    // reload on start, count down to zero otherwise
    always @(posedge clk) begin
        if (rst) begin
            count_q <= {WIDTH{1'b0}};
            busy    <= 1'b0;
        end else if (start) begin
            count_q <= CYCLES[WIDTH-1:0];
            busy    <= 1'b1;
        end else if (count_q != {WIDTH{1'b0}}) begin
            count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
            busy    <= (count_q != {{(WIDTH-1){1'b0}}, 1'b1});
        end else begin
            busy    <= 1'b0;
        end
    end
endmodule
